// ==== hdl/aord_pkg.sv ====
// constants and types for the over-range detector block
package aord_pkg;
  localparam int unsigned aord_sample_w = 12;
  localparam int unsigned aord_mag_w = 11;
  localparam int unsigned aord_cmp_w = 8;
  localparam int unsigned aord_cmp_lsb = 3;
  localparam int unsigned aord_hold_sel_w = 3;
  localparam int unsigned aord_hold_cnt_w = 11;
  localparam int unsigned aord_chan_count = 4;
  localparam int unsigned aord_core_count = 6;
  localparam int unsigned aord_offset_count = 6;
  localparam int unsigned aord_trim_w = 8;
  localparam int unsigned aord_fs_w = 16;
  localparam logic [aord_mag_w-1:0] aord_mag_max = 11'h7ff;
  localparam logic [aord_sample_w-1:0] aord_code_min = 12'h800;
  localparam logic [aord_hold_cnt_w-1:0] aord_hold_base = 11'h008;
  localparam logic [aord_cmp_w-1:0] aord_thresh_reset = 8'h00;
  localparam logic [aord_hold_sel_w-1:0] aord_hold_sel_reset = 3'h0;
  localparam logic [aord_fs_w-1:0] aord_fs_reset = 16'h0000;
  localparam logic [aord_trim_w-1:0] aord_trim_reset = 8'h00;
  localparam int unsigned aord_cal_cycles = 64;
  localparam logic [6:0] aord_cal_len = 7'(aord_cal_cycles - 1);
  typedef enum logic [1:0] {aord_cal_off, aord_cal_fore, aord_cal_back} aord_cal_mode_t;
  typedef enum {aord_st_run, aord_st_fore_cal} aord_state_t;
endpackage : aord_pkg

// ==== hdl/aord_channel.sv ====
// one channel: magnitude, threshold compare and hold counter
`timescale 1ns/1ps
`default_nettype none
module aord_channel
  import aord_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // sample and settings
  input wire logic sample_valid,
  input wire logic [aord_pkg::aord_sample_w-1:0] sample,
  input wire logic enable,
  input wire logic [aord_pkg::aord_cmp_w-1:0] threshold,
  input wire logic [aord_pkg::aord_hold_sel_w-1:0] hold_select,
  // flag
  output logic flag
);
  import aord_pkg::*;

  logic [aord_hold_cnt_w-1:0] hold_left;
  logic hit;

  function automatic logic [aord_mag_w-1:0] magnitude(input logic [aord_sample_w-1:0] s);
    logic [aord_sample_w-1:0] neg;
    neg = -s;
    if (s == aord_code_min)
      magnitude = aord_mag_max;
    else if (s[aord_sample_w-1])
      magnitude = neg[aord_mag_w-1:0];
    else
      magnitude = s[aord_mag_w-1:0];
  endfunction : magnitude

  function automatic logic [aord_hold_cnt_w-1:0] hold_length(input logic [aord_hold_sel_w-1:0] sel);
    hold_length = aord_hold_base << sel;
  endfunction : hold_length

  always_comb
  begin
    logic [aord_mag_w-1:0] m;
    m = magnitude(sample);
    hit = sample_valid && (m[aord_mag_w-1:aord_cmp_lsb] >= threshold);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hold_left <= '0;
    else if (hit)
      hold_left <= hold_length(hold_select) - 1'b1;
    else if (hold_left != '0)
      hold_left <= hold_left - 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else
      flag <= enable && (hit || hold_left != '0);
  end
endmodule : aord_channel
`default_nettype wire

// ==== hdl/aord_top.sv ====
// over-range detector with sample path settings for a quad converter
`timescale 1ns/1ps
`default_nettype none
module aord_top
  import aord_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // converted codes from channel a to d
  input wire logic [aord_pkg::aord_sample_w-1:0] chan_a_code,
  input wire logic [aord_pkg::aord_sample_w-1:0] chan_b_code,
  input wire logic [aord_pkg::aord_sample_w-1:0] chan_c_code,
  input wire logic [aord_pkg::aord_sample_w-1:0] chan_d_code,
  // detector settings
  input wire logic overrange_detect_enable,
  input wire logic [aord_pkg::aord_cmp_w-1:0] overrange_threshold,
  input wire logic [aord_pkg::aord_hold_sel_w-1:0] overrange_hold_select,
  // shared and per-core trims
  input wire logic [aord_pkg::aord_fs_w-1:0] fullscale_setting,
  input wire logic trim_write,
  input wire logic [2:0] trim_index,
  input wire logic [aord_pkg::aord_trim_w-1:0] core_input_offset_trim,
  // calibration control
  input wire logic [1:0] cal_mode,
  input wire logic cal_start,
  // sample outputs
  output logic [aord_pkg::aord_sample_w-1:0] chan_a_sample,
  output logic [aord_pkg::aord_sample_w-1:0] chan_b_sample,
  output logic [aord_pkg::aord_sample_w-1:0] chan_c_sample,
  output logic [aord_pkg::aord_sample_w-1:0] chan_d_sample,
  output logic sample_valid,
  // over-range pins
  output logic chan_a_overrange_pin,
  output logic chan_b_overrange_pin,
  output logic chan_c_overrange_pin,
  output logic chan_d_overrange_pin,
  // settings readback and status
  output logic [aord_pkg::aord_fs_w-1:0] fullscale_applied,
  output logic [aord_pkg::aord_trim_w-1:0] trim_readback,
  output logic [2:0] cal_spare_core,
  output logic cal_busy
);
  import aord_pkg::*;

  logic rst_meta;
  logic rst_sync_n;
  logic [aord_sample_w-1:0] code_q [aord_chan_count];
  logic [aord_chan_count-1:0] flags;
  logic [aord_trim_w-1:0] offset_trim [aord_offset_count];
  aord_state_t state;
  logic [6:0] cal_count;
  logic [2:0] trim_rd_index;

  // reset release through two flops
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // calibration sequencer
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state <= aord_st_run;
      cal_count <= '0;
    end
    else
      unique case (state)
        aord_st_run:
          if (cal_start && cal_mode == aord_cal_fore)
          begin
            state <= aord_st_fore_cal;
            cal_count <= aord_cal_len;
          end
        aord_st_fore_cal:
          if (cal_count == '0)
            state <= aord_st_run;
          else
            cal_count <= cal_count - 1'b1;
      endcase
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cal_busy <= 1'b0;
    else
      cal_busy <= (state == aord_st_fore_cal);
  end

  // spare core rotates through the six cores in background mode
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cal_spare_core <= '0;
    else if (cal_mode == aord_cal_back && cal_start)
      cal_spare_core <= (cal_spare_core == 3'(aord_core_count - 1)) ? 3'h0 : cal_spare_core + 3'h1;
  end

  // sample capture on the rising clock edge, paused by foreground cal
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      code_q <= '{default: '0};
      sample_valid <= 1'b0;
    end
    else
    begin
      sample_valid <= (state == aord_st_run);
      if (state == aord_st_run)
      begin
        code_q[0] <= chan_a_code;
        code_q[1] <= chan_b_code;
        code_q[2] <= chan_c_code;
        code_q[3] <= chan_d_code;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      chan_a_sample <= '0;
      chan_b_sample <= '0;
      chan_c_sample <= '0;
      chan_d_sample <= '0;
    end
    else
    begin
      chan_a_sample <= code_q[0];
      chan_b_sample <= code_q[1];
      chan_c_sample <= code_q[2];
      chan_d_sample <= code_q[3];
    end
  end

  // per-channel detectors sharing one threshold
  for (genvar i = 0; i < aord_chan_count; i++)
  begin : g_chan
    aord_channel u_chan (
      .clock(clock),
      .rst_n(rst_sync_n),
      .sample_valid(sample_valid),
      .sample(code_q[i]),
      .enable(overrange_detect_enable),
      .threshold(overrange_threshold),
      .hold_select(overrange_hold_select),
      .flag(flags[i])
    );
  end

  // dedicated pins, one per channel
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      chan_a_overrange_pin <= 1'b0;
      chan_b_overrange_pin <= 1'b0;
      chan_c_overrange_pin <= 1'b0;
      chan_d_overrange_pin <= 1'b0;
    end
    else
    begin
      chan_a_overrange_pin <= flags[0];
      chan_b_overrange_pin <= flags[1];
      chan_c_overrange_pin <= flags[2];
      chan_d_overrange_pin <= flags[3];
    end
  end

  // one shared full-scale setting
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      fullscale_applied <= aord_fs_reset;
    else
      fullscale_applied <= fullscale_setting;
  end

  // offset trims: cores 0,1 ; 2a,2b ; 3c,3d  and 4,5 mapped by index
  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      offset_trim <= '{default: aord_trim_reset};
      trim_rd_index <= '0;
    end
    else
    begin
      trim_rd_index <= trim_index;
      if (trim_write && trim_index < 3'(aord_offset_count))
        offset_trim[trim_index] <= core_input_offset_trim;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      trim_readback <= '0;
    else if (trim_rd_index < 3'(aord_offset_count))
      trim_readback <= offset_trim[trim_rd_index];
    else
      trim_readback <= '0;
  end
endmodule : aord_top
`default_nettype wire

// ==== testbench/aord_props.sv ====
// port assertions for the over-range detector
`timescale 1ns/1ps
`default_nettype none
module aord_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // inputs
  input wire logic [11:0] chan_a_code,
  input wire logic [11:0] chan_b_code,
  input wire logic overrange_detect_enable,
  input wire logic [7:0] overrange_threshold,
  input wire logic [2:0] overrange_hold_select,
  input wire logic [15:0] fullscale_setting,
  // outputs
  input wire logic [11:0] chan_a_sample,
  input wire logic sample_valid,
  input wire logic chan_a_overrange_pin,
  input wire logic chan_b_overrange_pin,
  input wire logic [15:0] fullscale_applied,
  input wire logic cal_busy
);
  logic [11:0] age_a;
  logic hit_a_q;
  function automatic logic hits(logic [11:0] c, logic [7:0] t);
    logic [10:0] m;
    m = c[11] ? ((c == 12'h800) ? 11'h7ff : 11'(-c)) : c[10:0];
    return m[10:3] >= t;
  endfunction : hits
  wire logic hit_a = hits(chan_a_code, overrange_threshold);
  wire logic hit_b = hits(chan_b_code, overrange_threshold);
  // a hit counts only when the code was captured, seen as valid one cycle on
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      hit_a_q <= 1'b0;
    else
      hit_a_q <= hit_a;
  end
  // cycles since the last captured hit on channel a
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      age_a <= 12'hfff;
    else if (hit_a_q && sample_valid)
      age_a <= 12'h001;
    else if (age_a != 12'hfff)
      age_a <= age_a + 12'h001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_hit;
    overrange_detect_enable && hit_a ##1 sample_valid && overrange_detect_enable ##1 overrange_detect_enable;
  endsequence
  sequence s_quiet;
    !hit_a && overrange_hold_select == 3'h0 && $stable(overrange_threshold);
  endsequence
  a_hit_sets_pin: assert property (s_hit |=> chan_a_overrange_pin)
    else $error("pin a missed a hit");
  a_quiet_clears_pin: assert property (s_quiet [*8] ##1 s_quiet [*2] |=> !chan_a_overrange_pin)
    else $error("pin a high without a hit");
  a_disable_holds_low: assert property (!overrange_detect_enable [*3] |-> !chan_a_overrange_pin)
    else $error("pin a high while disabled");
  a_hold_pulse_length: assert property ($fell(chan_a_overrange_pin) && overrange_detect_enable
    && $past(overrange_detect_enable, 2) |-> age_a == (12'h008 << overrange_hold_select) + 12'h002)
    else $error("pin a pulse length wrong");
  a_rise_needs_hit: assert property ($rose(chan_b_overrange_pin) |-> $past(hit_b, 3))
    else $error("pin b rose without a hit");
  a_sample_delay: assert property (sample_valid && $past(sample_valid)
    |-> chan_a_sample == $past(chan_a_code, 2))
    else $error("sample a wrong");
  a_fullscale_copy: assert property ($past(rst_n, 3) |-> fullscale_applied == $past(fullscale_setting))
    else $error("full scale not applied");
  a_fg_no_valid: assert property (cal_busy |-> !sample_valid)
    else $error("valid during calibration");
endmodule : aord_props
bind aord_top aord_props u_props (.*);
`default_nettype wire

// ==== testbench/aord_gain_ctl.sv ====
// downstream gain control model watching the flag pins
`timescale 1ns/1ps
`default_nettype none
module aord_gain_ctl (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // flag pins
  input wire logic [3:0] flags,
  // controls
  output logic [7:0] thr_hint,
  output logic gain_cut
);
  assign thr_hint = 8'he4;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      gain_cut <= 1'b0;
    else
      gain_cut <= |flags;
  end
endmodule : aord_gain_ctl
`default_nettype wire

// ==== testbench/adc_overrange_detector_bench.sv ====
// testbench for the over-range detector
`timescale 1ns/1ps
`default_nettype none
module adc_overrange_detector_bench;
  logic clock = 0;
  logic rst_n = 0;
  logic overrange_detect_enable = 1;
  logic trim_write = 0;
  logic cal_start = 0;
  logic use_ctl = 0;
  logic sample_valid, cal_busy, gain_cut;
  logic chan_a_overrange_pin, chan_b_overrange_pin, chan_c_overrange_pin, chan_d_overrange_pin;
  logic [11:0] chan_a_code = '0, chan_b_code = '0, chan_c_code = '0, chan_d_code = '0;
  logic [11:0] chan_a_sample, chan_b_sample, chan_c_sample, chan_d_sample;
  logic [7:0] thr = 8'hff, core_input_offset_trim = '0, trim_readback, thr_hint;
  logic [2:0] overrange_hold_select = '0, trim_index = '0, cal_spare_core;
  logic [1:0] cal_mode = '0;
  logic [15:0] fullscale_setting = '0, fullscale_applied;
  int n_fail = 0, checks_done = 0, hi = 0, k;
  wire logic [7:0] overrange_threshold = use_ctl ? thr_hint : thr;
  wire logic [3:0] pins = {chan_d_overrange_pin, chan_c_overrange_pin, chan_b_overrange_pin, chan_a_overrange_pin};
  // expected flag, code, threshold
  logic [20:0] tab [8] = '{21'h17_ffff, 21'h07_f0ff, 21'h17_f0fe, 21'h18_10fe,
                           21'h18_00ff, 21'h07_f7ff, 21'h00_0802, 21'h18_08ff};
  aord_top dut_u (.*);
  aord_gain_ctl ctl_u (.clock(clock), .rst_n(rst_n), .flags(pins), .thr_hint(thr_hint), .gain_cut(gain_cut));
  always #12.5 clock = ~clock;
  task cyc(int n);
    repeat (n)
    begin
      @(negedge clock);
      hi += chan_a_overrange_pin;
    end
  endtask : cyc
  task chk(logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task hit(logic [11:0] c);
    {chan_a_code, chan_b_code, chan_c_code, chan_d_code} = {4{c}};
    cyc(1);
    {chan_a_code, chan_b_code, chan_c_code, chan_d_code} = '0;
  endtask : hit
  task test_done;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    cyc(6);
    rst_n = 1;
    cyc(6);
    for (k = 0; k < 8; k++)
    begin
      thr = tab[k][7:0];
      cyc(2);
      hit(tab[k][19:8]);
      cyc(1);
      chk(chan_d_sample, tab[k][19:8]);
      chk(chan_a_sample, tab[k][19:8]);
      chk(chan_b_sample, tab[k][19:8]);
      chk(chan_c_sample, tab[k][19:8]);
      cyc(1);
      chk(pins, {4{tab[k][20]}});
      cyc(12);
    end
    chan_c_code = 12'h7ff;
    cyc(1);
    chan_c_code = '0;
    cyc(2);
    chk(pins, 16'h0004);
    cyc(12);
    thr = 8'hf0;
    for (k = 0; k < 8; k++)
    begin
      overrange_hold_select = 3'(k);
      cyc(2);
      hi = 0;
      hit(12'h7ff);
      cyc(1040);
      chk(16'(hi), 16'(8 << k));
    end
    overrange_hold_select = 0;
    hi = 0;
    hit(12'h801);
    cyc(4);
    hit(12'h801);
    cyc(30);
    chk(16'(hi), 16'h000d);
    overrange_detect_enable = 0;
    hit(12'h7ff);
    cyc(20);
    chk(16'(hi), 16'h000d);
    overrange_detect_enable = 1;
    use_ctl = 1;
    cyc(2);
    hit(12'h8e0);
    cyc(3);
    chk(gain_cut, 1);
    cyc(15);
    chk(gain_cut, 0);
    use_ctl = 0;
    fullscale_setting = 16'ha5c3;
    cyc(2);
    chk(fullscale_applied, 16'ha5c3);
    trim_write = 1;
    for (k = 0; k < 8; k++)
    begin
      trim_index = 3'(k);
      core_input_offset_trim = 8'(8'h10 + k);
      cyc(1);
    end
    trim_write = 0;
    for (k = 0; k < 8; k++)
    begin
      trim_index = 3'(k);
      cyc(2);
      chk(trim_readback, (k < 6) ? 16'(8'h10 + k) : 16'h0000);
    end
    cal_mode = 2;
    for (k = 0; k < 6; k++)
    begin
      cal_start = 1;
      cyc(1);
      cal_start = 0;
      cyc(2);
      chk({sample_valid, cal_spare_core}, 16'(8 + (k + 1) % 6));
    end
    cal_mode = 1;
    cal_start = 1;
    cyc(1);
    cal_start = 0;
    cyc(2);
    chk({cal_busy, sample_valid}, 16'h0002);
    hi = 0;
    hit(12'h7ff);
    for (k = 0; k < 200 && cal_busy !== 1'b0; k++)
      cyc(1);
    chk(cal_busy, 0);
    if (cal_busy === 1'b0)
    begin
      cyc(3);
      chk({sample_valid, 15'(hi)}, 16'h8000);
    end
    test_done;
  end
endmodule : adc_overrange_detector_bench
`default_nettype wire
